// >>> core/spi_fault_pkg.sv
package spi_fault_pkg;

  // serial word length seen on the link when acting as slave
  localparam int BYTE_BITS_DEF = 8;

  // stages in every level or toggle synchroniser
  localparam int SYNC_STAGES = 2;

  // reset values of the control and status state
  localparam logic MASTER_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic IRQ_RST = 1'b0;
  localparam logic FAULT_RST = 1'b0;
  localparam logic TGL_RST = 1'b0;

  // idle level of the select pin; it is active low
  localparam logic SS_IDLE = 1'b1;

  // pin defaults while nothing drives the bus
  localparam logic PIN_RST = 1'b0;
  localparam logic OE_OFF = 1'b0;

  // operating role of the unit as seen on the pins
  typedef enum logic [1:0] {
    ROLE_OFF,
    ROLE_MASTER,
    ROLE_SLAVE
  } role_type;

endpackage

// >>> core/spi_master_mode_fault.sv
// Functional notes
// - low select input while master means selected
// - fault clears master_select_bit, unit becomes slave
// - after fault, data-out and clock pins release
// - fault sets transfer_complete_flag
// - interrupt only with both enables set
// - select as output is plain output
module spi_master_mode_fault #(
  parameter int BYTE_BITS = spi_fault_pkg::BYTE_BITS_DEF
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,

  // control bits written by software
  input wire logic spi_enable_i,
  input wire logic master_set_i,
  input wire logic master_clr_i,
  input wire logic spi_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic flag_clr_i,

  // select pin direction and output value
  input wire logic ss_dir_out_i,
  input wire logic ss_gpo_i,

  // data-out and clock levels from the master shifter
  input wire logic mosi_drive_i,
  input wire logic sck_drive_i,

  // select pin, two-way
  input wire logic ss_in_i,
  output logic ss_o,
  output logic ss_oe_o,

  // data-out pin, two-way
  input wire logic mosi_in_i,
  output logic mosi_o,
  output logic mosi_oe_o,

  // clock pin: input side clocks the link logic
  input wire logic sck_in_i,
  output logic sck_o,
  output logic sck_oe_o,

  // status seen by software
  output logic master_select_bit_o,
  output logic transfer_complete_flag_o,
  output logic mode_fault_o,
  output logic [BYTE_BITS-1:0] rx_data_o,

  // interrupt request towards the core
  output logic spi_irq_o
);

  import spi_fault_pkg::*;

  localparam int CNT_W = (BYTE_BITS > 1) ? $clog2(BYTE_BITS) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BYTE_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // system domain state
  logic master_r;
  logic master_nxt;
  logic flag_r;
  logic flag_nxt;
  logic fault_r;
  logic irq_r;
  logic ss_r;
  logic ss_oe_r;
  logic mosi_r;
  logic mosi_oe_r;
  logic sck_r;
  logic sck_oe_r;
  logic tgl_seen_r;
  logic [BYTE_BITS-1:0] rx_data_r;
  role_type role_nxt;

  // link domain state, clocked by the incoming serial clock
  logic [CNT_W-1:0] bit_cnt_r;
  logic [BYTE_BITS-1:0] shift_r;
  logic [BYTE_BITS-1:0] rx_hold_r;
  logic byte_tgl_r;
  logic link_rst_n;

  // crossing wires
  logic ss_sync;
  logic tgl_sync;

  // decode wires
  logic ss_is_input;
  logic select_fault;
  logic byte_event;
  logic slave_byte_done;
  logic drive_bus;
  logic irq_nxt;
  logic [BYTE_BITS-1:0] shift_nxt;
  logic cnt_wrap;
  logic [CNT_W-1:0] cnt_nxt;
  logic byte_last;

  // select pin enters through two flops before the fault decision; the link logic takes it raw
  sync_stages #(
    .WIDTH(1),
    .STAGES(SYNC_STAGES),
    .RST_VAL(SS_IDLE)
  ) u_ss_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(ss_in_i),
    .q_o(ss_sync)
  );

  // byte-complete toggle from the link domain
  sync_stages #(
    .WIDTH(1),
    .STAGES(SYNC_STAGES),
    .RST_VAL(TGL_RST)
  ) u_tgl_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(byte_tgl_r),
    .q_o(tgl_sync)
  );

  // fault detection
  // as an output the select pin never feeds the fault logic
  assign ss_is_input = ~ss_dir_out_i;
  // a single synchronised low sample is enough; no filter, so a glitch
  // longer than one clock on the select input does trip the fallback
  assign select_fault = spi_enable_i & master_r & ss_is_input
                        & ~ss_sync;

  // new byte from the link, honoured only while acting as slave
  assign byte_event = tgl_sync ^ tgl_seen_r;
  assign slave_byte_done = byte_event & spi_enable_i & ~master_r;

  // next-state decode
  // fault wins over a software set in the same cycle: contention on
  // the shared bus is worse than a lost write, and software rewrites
  assign master_nxt = select_fault ? 1'b0 :
                      master_set_i ? 1'b1 :
                      master_clr_i ? 1'b0 :
                      master_r;

  // hardware set wins over the software clear
  assign flag_nxt = (select_fault | slave_byte_done) ? 1'b1 :
                    flag_clr_i ? 1'b0 :
                    flag_r;

  // request needs the flag and both enables at once
  assign irq_nxt = flag_nxt & spi_irq_enable_i
                   & global_irq_enable_i;

  // role after this edge; bus pins driven only as enabled master
  assign role_nxt = !spi_enable_i ? ROLE_OFF :
                    master_nxt ? ROLE_MASTER :
                    ROLE_SLAVE;
  assign drive_bus = (role_nxt == ROLE_MASTER);

  // master bit; cleared by the fault, set again only by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_r <= MASTER_RST;
    end else begin
      master_r <= master_nxt;
    end
  end

  // sticky completion flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // fault strobe, high for the one cycle of the fallback
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= FAULT_RST;
    end else begin
      fault_r <= select_fault;
    end
  end

  // interrupt request, one flop behind the enables, in step with the flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= IRQ_RST;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // data-out pin; enable drops in the edge that clears the master
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mosi_r <= PIN_RST;
      mosi_oe_r <= OE_OFF;
    end else begin
      mosi_r <= mosi_drive_i;
      mosi_oe_r <= drive_bus;
    end
  end

  // clock pin, same enable so both lines release together
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_r <= PIN_RST;
      sck_oe_r <= OE_OFF;
    end else begin
      sck_r <= sck_drive_i;
      sck_oe_r <= drive_bus;
    end
  end

  // select pin as plain output, independent of the serial role
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_r <= SS_IDLE;
      ss_oe_r <= OE_OFF;
    end else begin
      ss_r <= ss_gpo_i;
      ss_oe_r <= ss_dir_out_i;
    end
  end

  // last toggle level seen, for the byte edge detector
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_seen_r <= TGL_RST;
    end else begin
      tgl_seen_r <= tgl_sync;
    end
  end

  // received byte taken once the toggle has settled; the holding
  // register stays still for a whole byte, long past the sync delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_data_r <= '0;
    end else begin
      if (byte_event) begin
        rx_data_r <= rx_hold_r;
      end
    end
  end

  // link domain: slave receive on the incoming clock
  // the frame ends with the select going high, and the clock may stop
  // then, so the select level itself resets the bit count
  assign link_rst_n = rst_n_i & ~ss_in_i;

  // sampling on the rising edge only; other clock phases are outside
  // the scope of this unit
  assign shift_nxt = {shift_r[BYTE_BITS-2:0], mosi_in_i};
  // bit count wraps after the last bit of each byte
  assign cnt_wrap = (bit_cnt_r == CNT_LAST);
  assign cnt_nxt = cnt_wrap ? CNT_ZERO : bit_cnt_r + 1'b1;
  // last bit of a byte while the frame is still open
  assign byte_last = ~ss_in_i & cnt_wrap;

  // shift register, cleared between frames
  always_ff @(posedge sck_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // bit position; a cut frame drops its partial byte
  always_ff @(posedge sck_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_r <= CNT_ZERO;
    end else begin
      bit_cnt_r <= cnt_nxt;
    end
  end

  // byte hold and toggle survive the end of the frame
  always_ff @(posedge sck_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_r <= '0;
      byte_tgl_r <= TGL_RST;
    end else if (byte_last) begin
      rx_hold_r <= shift_nxt;
      byte_tgl_r <= ~byte_tgl_r;
    end
  end

  // outputs, all straight from flops
  assign ss_o = ss_r;
  assign ss_oe_o = ss_oe_r;
  assign mosi_o = mosi_r;
  assign mosi_oe_o = mosi_oe_r;
  assign sck_o = sck_r;
  assign sck_oe_o = sck_oe_r;
  // software reads this to tell a fault apart from a finished byte
  assign master_select_bit_o = master_r;
  assign transfer_complete_flag_o = flag_r;
  assign mode_fault_o = fault_r;
  assign rx_data_o = rx_data_r;
  assign spi_irq_o = irq_r;

endmodule

// >>> core/sync_stages.sv
// plain multi-stage synchroniser; the first stage is read only by the next
module sync_stages #(
  parameter int WIDTH = 1,
  parameter int STAGES = spi_fault_pkg::SYNC_STAGES,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_n_i,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage_r [STAGES];

  // shift chain; only the last stage leaves the module
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_r[i] <= RST_VAL;
      end
    end else begin
      stage_r[0] <= d_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign q_o = stage_r[STAGES-1];

endmodule

// >>> sim/spi_far_master.sv
module spi_far_master (
  // lines driven onto the shared bus
  output logic ss_n_o,
  output logic sck_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: select high, clock stands still low
  initial begin
    ss_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b1;
  end
  task automatic select(input logic lvl);
    ss_n_o = lvl;
  endtask
  // mode 0, msb first, 160 ns clock only inside the frame
  task automatic send_byte(input logic [7:0] b);
    #13;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      #80 sck_o = 1'b1;
      #80 sck_o = 1'b0;
    end
    mosi_o = ~b[0]; // released line must not hold the last bit
  endtask
endmodule

// >>> sim/spi_fault_assertions.sv
module spi_fault_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control inputs
  input wire logic spi_enable_i,
  input wire logic master_set_i,
  input wire logic spi_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic flag_clr_i,
  input wire logic ss_dir_out_i,
  input wire logic ss_gpo_i,
  input wire logic ss_in_i,
  // watched outputs
  input wire logic ss_o,
  input wire logic ss_oe_o,
  input wire logic mosi_oe_o,
  input wire logic sck_oe_o,
  input wire logic master_select_bit_o,
  input wire logic transfer_complete_flag_o,
  input wire logic mode_fault_o,
  input wire logic spi_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // master with select as input; the sync delay is two edges
  wire logic armed = spi_enable_i && master_select_bit_o && !ss_dir_out_i;
  a_fault_drops_master: assert property (armed && !$past(ss_in_i, 2) |=>
    !master_select_bit_o && mode_fault_o) else $error("no fallback");
  a_fault_frees_pins: assert property (armed && !$past(ss_in_i, 2) |=>
    !mosi_oe_o && !sck_oe_o) else $error("pins still driven");
  a_fault_sets_flag: assert property (mode_fault_o |->
    transfer_complete_flag_o) else $error("flag not set");
  a_irq_both_enables: assert property (spi_irq_o == (transfer_complete_flag_o
    && $past(spi_irq_enable_i) && $past(global_irq_enable_i)))
    else $error("irq mismatch");
  a_master_no_restore: assert property (!master_select_bit_o &&
    !master_set_i |=> !master_select_bit_o) else $error("self restore");
  a_select_plain_out: assert property ($past(rst_n_i) |-> ss_o ==
    $past(ss_gpo_i) && ss_oe_o == $past(ss_dir_out_i))
    else $error("select out");
  a_out_select_no_fault: assert property (ss_dir_out_i |=> !mode_fault_o)
    else $error("fault with output");
  a_fault_one_pulse: assert property (mode_fault_o |=> !mode_fault_o)
    else $error("fault too long");
  a_flag_sticky: assert property (transfer_complete_flag_o && !flag_clr_i |=>
    transfer_complete_flag_o) else $error("flag lost");
  a_off_no_drive: assert property (!spi_enable_i |=>
    !mosi_oe_o && !sck_oe_o) else $error("pins driven while off");
  a_off_no_fault: assert property (!spi_enable_i |=>
    !mode_fault_o) else $error("fault while off");
  c_fault: cover property (mode_fault_o);
  c_irq: cover property (spi_irq_o);
  c_slave_flag: cover property (!master_select_bit_o && !mode_fault_o
    ##1 transfer_complete_flag_o && !$past(transfer_complete_flag_o));
endmodule

bind spi_master_mode_fault spi_fault_checker i_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .spi_enable_i(spi_enable_i),
  .master_set_i(master_set_i), .spi_irq_enable_i(spi_irq_enable_i),
  .global_irq_enable_i(global_irq_enable_i), .flag_clr_i(flag_clr_i),
  .ss_dir_out_i(ss_dir_out_i), .ss_gpo_i(ss_gpo_i), .ss_in_i(ss_in_i),
  .ss_o(ss_o), .ss_oe_o(ss_oe_o), .mosi_oe_o(mosi_oe_o),
  .sck_oe_o(sck_oe_o), .master_select_bit_o(master_select_bit_o),
  .transfer_complete_flag_o(transfer_complete_flag_o),
  .mode_fault_o(mode_fault_o), .spi_irq_o(spi_irq_o));

// >>> sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spi_fault_pkg::*;
  logic clk_i, rst_n_i, spi_enable_i, master_set_i, master_clr_i;
  logic spi_irq_enable_i, global_irq_enable_i, flag_clr_i;
  logic ss_dir_out_i, ss_gpo_i, mosi_drive_i, sck_drive_i;
  logic ss_o, ss_oe_o, mosi_o, mosi_oe_o, sck_o, sck_oe_o;
  logic master_select_bit_o, transfer_complete_flag_o, mode_fault_o;
  logic spi_irq_o;
  logic [7:0] rx_data_o;
  wire logic far_ss, far_sck, far_mosi;
  int error_cnt = 0;
  int check_count = 0;
  // wire levels resolved from the unit's enables; the far master drives otherwise
  wire logic ss_in_i = ss_oe_o ? ss_o : far_ss;
  wire logic sck_in_i = sck_oe_o ? sck_o : far_sck;
  wire logic mosi_in_i = mosi_oe_o ? mosi_o : far_mosi;
  spi_master_mode_fault i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .spi_enable_i(spi_enable_i), .master_set_i(master_set_i),
    .master_clr_i(master_clr_i), .spi_irq_enable_i(spi_irq_enable_i),
    .global_irq_enable_i(global_irq_enable_i), .flag_clr_i(flag_clr_i),
    .ss_dir_out_i(ss_dir_out_i), .ss_gpo_i(ss_gpo_i),
    .mosi_drive_i(mosi_drive_i), .sck_drive_i(sck_drive_i),
    .ss_in_i(ss_in_i), .ss_o(ss_o), .ss_oe_o(ss_oe_o),
    .mosi_in_i(mosi_in_i), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .sck_in_i(sck_in_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .master_select_bit_o(master_select_bit_o),
    .transfer_complete_flag_o(transfer_complete_flag_o),
    .mode_fault_o(mode_fault_o), .rx_data_o(rx_data_o),
    .spi_irq_o(spi_irq_o));
  spi_far_master i_far (.ss_n_o(far_ss), .sck_o(far_sck),
    .mosi_o(far_mosi));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic pulse_set();
    master_set_i = 1'b1;
    step(1);
    master_set_i = 1'b0;
  endtask
  // fallback with each interrupt enable pair
  task automatic t_fault(input logic ie, input logic ge);
    int n;
    spi_irq_enable_i = ie;
    global_irq_enable_i = ge;
    pulse_set();
    chk("oe before", 8'h01, {7'h00, mosi_oe_o & sck_oe_o});
    i_far.select(1'b0);
    for (n = 0; n < 20 && mode_fault_o !== 1'b1; n++) step(1);
    if (n == 20) begin
      $display("[FAIL] fault wait expected 1 seen %b", mode_fault_o);
      error_cnt++;
      summarize();
    end
    chk("master", 8'h00, {7'h00, master_select_bit_o});
    chk("pin oe", 8'h00, {6'h00, mosi_oe_o, sck_oe_o});
    chk("flag", 8'h01, {7'h00, transfer_complete_flag_o});
    chk("irq", {7'h00, ie & ge}, {7'h00, spi_irq_o});
    i_far.select(1'b1);
    step(6);
    chk("no restore", 8'h00, {7'h00, master_select_bit_o});
    flag_clr_i = 1'b1;
    step(1);
    flag_clr_i = 1'b0;
    chk("flag clear", 8'h00, {7'h00, transfer_complete_flag_o});
    $display("fault test done ie=%b ge=%b", ie, ge);
  endtask
  // select as output: low level drives the pin, no fallback
  task automatic t_ss_out();
    ss_dir_out_i = 1'b1;
    ss_gpo_i = 1'b0;
    mosi_drive_i = 1'b0;
    pulse_set();
    step(4);
    chk("pin level", 8'h01, {6'h00, mosi_o, sck_o});
    mosi_drive_i = 1'b1;
    chk("ss drive", 8'h10, {3'h0, ss_oe_o, 3'h0, ss_o});
    chk("master kept", 8'h01, {7'h00, master_select_bit_o});
    ss_gpo_i = 1'b1;
    master_clr_i = 1'b1;
    step(1);
    master_clr_i = 1'b0;
    ss_dir_out_i = 1'b0;
    chk("master clr", 8'h00, {7'h00, master_select_bit_o});
    $display("select output test done");
  endtask
  // unit disabled: no drive and no fallback while selected
  task automatic t_disabled();
    spi_enable_i = 1'b0;
    pulse_set();
    chk("oe off", 8'h00, {6'h00, mosi_oe_o, sck_oe_o});
    i_far.select(1'b0);
    step(4);
    chk("no fault", 8'h01, {7'h00, master_select_bit_o});
    i_far.select(1'b1);
    master_clr_i = 1'b1;
    step(1);
    master_clr_i = 1'b0;
    step(2);
    spi_enable_i = 1'b1;
    $display("disabled test done");
  endtask
  // as slave after a software clear, a byte from the far master lands
  task automatic t_slave_byte();
    int n;
    i_far.select(1'b0);
    i_far.send_byte(8'hA5);
    for (n = 0; n < 20 && rx_data_o !== 8'hA5; n++) step(1);
    if (n == 20) begin
      $display("[FAIL] rx wait expected a5 seen %h", rx_data_o);
      error_cnt++;
      summarize();
    end
    step(2);
    chk("rx", 8'hA5, rx_data_o);
    chk("rx flag", 8'h01, {7'h00, transfer_complete_flag_o});
    i_far.select(1'b1);
    $display("slave byte test done");
  endtask
  initial begin
    {master_set_i, master_clr_i, flag_clr_i, ss_dir_out_i} = 4'h0;
    {spi_irq_enable_i, global_irq_enable_i, ss_gpo_i} = 3'h0;
    {spi_enable_i, mosi_drive_i, sck_drive_i} = 3'h7;
    rst_n_i = 1'b0;
    step(3);
    chk("reset ss", {7'h00, SS_IDLE}, {7'h00, ss_o});
    chk("reset master", 8'h00, {7'h00, master_select_bit_o});
    rst_n_i = 1'b1;
    step(1);
    for (int k = 0; k < 4; k++) t_fault(k[1], k[0]);
    t_disabled();
    t_ss_out();
    t_slave_byte();
    summarize();
  end
endmodule
